// *** bct_pkg.sv ***
// Constants, level codes and carrier types of the chop timing and fault supervisor
package bct_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_MHZ         = 20;
    localparam int unsigned BLANK_NS        = 860;
    localparam int unsigned OFF_US_LOW      = 7;
    localparam int unsigned OFF_US_HIGH     = 16;
    localparam int unsigned OFF_US_OPEN     = 24;
    localparam int unsigned OFF_US_RGND     = 32;
    localparam int unsigned SLP_MIN_US      = 18;
    localparam int unsigned SLP_MAX_US      = 35;
    localparam int unsigned OC_FILT_US      = 2;
    localparam int unsigned RETRY_US        = 4000;

    // Least times round up, longest times round down
    localparam logic [9:0]  BLANK_CYC       = 10'((BLANK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0]  OFF_CYC_LOW     = 10'(OFF_US_LOW * CLK_MHZ);
    localparam logic [9:0]  OFF_CYC_HIGH    = 10'(OFF_US_HIGH * CLK_MHZ);
    localparam logic [9:0]  OFF_CYC_OPEN    = 10'(OFF_US_OPEN * CLK_MHZ);
    localparam logic [9:0]  OFF_CYC_RGND    = 10'(OFF_US_RGND * CLK_MHZ);
    localparam logic [10:0] SLP_MIN_CYC     = 11'(SLP_MIN_US * CLK_MHZ);
    localparam logic [10:0] SLP_MAX_CYC     = 11'(SLP_MAX_US * CLK_MHZ);
    localparam logic [10:0] SLP_CNT_MAX     = 11'h7FF;
    localparam logic [7:0]  OC_FILT_CYC     = 8'(OC_FILT_US * CLK_MHZ);
    localparam int unsigned RETRY_CYC_DEF   = RETRY_US * CLK_MHZ;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] OFS_STATUS      = 12'h000;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h004;
    localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h008;
    localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h00C;
    localparam logic [11:0] OFS_CTRL        = 12'h010;

    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_SUPPLY      = 0;
    localparam int unsigned IRQ_PUMP        = 1;
    localparam int unsigned IRQ_OVERCUR     = 2;
    localparam int unsigned IRQ_THERMAL     = 3;
    localparam int unsigned CTRL_RUN        = 0;

    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 4'h0;
    localparam logic [31:0]      CTRL_RST       = 32'h0000_0001;

    // ==========================================================
    // Levels seen by the multi-level pin detectors
    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_HIGH,
        LVL_OPEN,
        LVL_RGND
    } bct_level_t;

    typedef struct packed {
        logic [1:0] off_time_select;
        logic [1:0] step_size_sel_a;
        logic [1:0] step_size_sel_b;
        logic [1:0] decay_sel_a;
        logic [1:0] decay_sel_b;
        logic [1:0] enable;
    } bct_pins_t;

    typedef struct packed {
        logic       supply_low;
        logic       pump_low;
        logic       thermal;
        logic [1:0] ilimit;
        logic [1:0] sense_trip;
    } bct_sense_t;

    typedef struct packed {
        logic [10:0] rsvd;
        logic [1:0]  chop_off;
        bct_level_t  enable;
        bct_level_t  decay_b;
        bct_level_t  decay_a;
        bct_level_t  step_b;
        bct_level_t  step_a;
        bct_level_t  off_time;
        logic        fault_line;
        logic        retry_mode;
        logic [1:0]  oc_trip;
        logic        thermal;
        logic        pump_low;
        logic        supply_low;
    } bct_status_t;

endpackage

// *** bct_supervisor.sv ***
// Chop timing, blanking and fault supervision with an AHB-Lite register slave
//
// What this block does
// - Off-time 7/16/24/32 us from select level
// - Off-time select change applies on the fly
// - Sense comparator ignored for 860 ns blanking
// - Drive phase lasts at least the blanking time
// - Supply low: bridges off, pump off, fault
// - Supply recovered: resume and release fault automatically
// - Pump low: bridges off, fault, pump keeps running
// - Pump recovered: resume and release fault automatically
// - Filtered overcurrent disables only that bridge
// - Enable open latches, enable high retries
// - Latched overcurrent held until sleep pulse
// - Retry resumes after delay and cleared overcurrent
// - Overtemperature: bridges off, fault, auto resume
// - Fault line open-drain, active low, released after reset
// - Decode four-level and three-level configuration inputs
// - Sleep low more than 18 and less than 35 us clears latched faults
// - Enable low holds bridge drivers high-impedance
`timescale 1ns/1ns
`default_nettype none

module bct_supervisor #(
    parameter int unsigned RETRY_CYC = bct_pkg::RETRY_CYC_DEF
) (
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    // AHB-Lite slave
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    output logic [31:0]             hrdata_o,
    // Pins and comparators
    input  wire bct_pkg::bct_pins_t  pins_i,
    input  wire bct_pkg::bct_sense_t sense_i,
    input  wire logic               sleep_request_low_i,
    input  wire logic               fault_flag_low_i,
    output logic                    fault_flag_low_o,
    output logic                    fault_flag_low_oe_o,
    output logic [1:0]              bridge_en_o,
    output logic [1:0]              bridge_drive_o,
    output logic                    pump_en_o,
    output logic                    irq_o
);
    import bct_pkg::*;

    // ==========================================================
    // Level decoding
    function automatic bct_level_t decode3(input logic [1:0] code);
        decode3 = (code == 2'h3) ? LVL_OPEN : bct_level_t'(code);
    endfunction

    function automatic bct_level_t decode4(input logic [1:0] code);
        decode4 = bct_level_t'(code);
    endfunction

    bct_level_t  lvl_off_sel;
    bct_level_t  lvl_step_a;
    bct_level_t  lvl_step_b;
    bct_level_t  lvl_decay_a;
    bct_level_t  lvl_decay_b;
    bct_level_t  lvl_enable;
    logic [9:0]  off_cyc;
    logic        retry_mode;
    logic        hold_off;

    assign lvl_off_sel = decode4(pins_i.off_time_select);
    assign lvl_step_b  = decode4(pins_i.step_size_sel_b);
    assign lvl_step_a  = decode3(pins_i.step_size_sel_a);
    assign lvl_decay_a = decode3(pins_i.decay_sel_a);
    assign lvl_decay_b = decode3(pins_i.decay_sel_b);
    assign lvl_enable  = decode3(pins_i.enable);

    assign retry_mode  = (lvl_enable == LVL_HIGH);
    assign hold_off    = (lvl_enable == LVL_LOW);

    // Live select, so a new setting takes effect within the running off phase
    always_comb begin
        unique case (lvl_off_sel)
            LVL_LOW:  off_cyc = OFF_CYC_LOW;
            LVL_HIGH: off_cyc = OFF_CYC_HIGH;
            LVL_OPEN: off_cyc = OFF_CYC_OPEN;
            LVL_RGND: off_cyc = OFF_CYC_RGND;
        endcase
    end

    // ==========================================================
    // Sleep reset pulse measurement
    logic        sleep_q;
    logic [10:0] slp_cnt_q;
    logic        slp_clear;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_q   <= 1'b1;
            slp_cnt_q <= 11'h000;
        end else begin
            sleep_q <= sleep_request_low_i;
            if (sleep_request_low_i) begin
                slp_cnt_q <= 11'h000;
            end else if (slp_cnt_q != SLP_CNT_MAX) begin
                slp_cnt_q <= slp_cnt_q + 11'h001;
            end
        end
    end

    // Rising edge ends the pulse; its width is the count of low cycles
    assign slp_clear = sleep_request_low_i && !sleep_q
                    && (slp_cnt_q > SLP_MIN_CYC) && (slp_cnt_q < SLP_MAX_CYC);

    // ==========================================================
    // Register state
    logic [IRQ_W-1:0] irq_sts_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [31:0]      ctrl_q;
    logic             run_en;

    assign run_en = ctrl_q[CTRL_RUN];

    // ==========================================================
    // Overcurrent filter and recovery, one per bridge
    logic [1:0] oc_trip_q;
    logic [1:0] oc_set;
    logic [1:0] chop_off;

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bridge
            logic [7:0]  filt_q;
            logic [31:0] retry_q;
            logic        oc_clr;

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    filt_q <= 8'h00;
                end else if (!sense_i.ilimit[b]) begin
                    filt_q <= 8'h00;
                end else if (filt_q != OC_FILT_CYC) begin
                    filt_q <= filt_q + 8'h01;
                end
            end

            assign oc_set[b] = sense_i.ilimit[b] && (filt_q >= OC_FILT_CYC - 8'h01);

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    retry_q <= 32'h0000_0000;
                end else if (oc_set[b]) begin
                    retry_q <= 32'h0000_0000;
                end else if (oc_trip_q[b] && retry_q != 32'(RETRY_CYC)) begin
                    retry_q <= retry_q + 32'h0000_0001;
                end
            end

            assign oc_clr = slp_clear
                         || (retry_mode && retry_q == 32'(RETRY_CYC)
                             && !sense_i.ilimit[b]);

            // Set wins over a clear in the same cycle
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    oc_trip_q[b] <= 1'b0;
                end else begin
                    oc_trip_q[b] <= oc_set[b] || (oc_trip_q[b] && !oc_clr);
                end
            end

            // ------------------------------------------------------
            // Chopper: drive with blanking, then fixed off time
            typedef enum logic {CH_DRIVE, CH_OFF} bct_chop_t;
            bct_chop_t   state_q;
            logic [9:0]  timer_q;
            logic        enabled;

            assign enabled = !hold_off && run_en && !sense_i.supply_low
                          && !sense_i.pump_low && !sense_i.thermal
                          && !oc_trip_q[b];

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    state_q <= CH_DRIVE;
                    timer_q <= 10'h000;
                end else if (!enabled) begin
                    state_q <= CH_DRIVE;
                    timer_q <= 10'h000;
                end else begin
                    unique case (state_q)
                        CH_DRIVE: begin
                            if (timer_q >= BLANK_CYC - 10'h001 && sense_i.sense_trip[b]) begin
                                state_q <= CH_OFF;
                                timer_q <= 10'h000;
                            end else if (timer_q < BLANK_CYC) begin
                                timer_q <= timer_q + 10'h001;
                            end
                        end
                        CH_OFF: begin
                            if (timer_q >= off_cyc - 10'h001) begin
                                state_q <= CH_DRIVE;
                                timer_q <= 10'h000;
                            end else begin
                                timer_q <= timer_q + 10'h001;
                            end
                        end
                    endcase
                end
            end

            assign chop_off[b] = (state_q == CH_OFF);

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    bridge_en_o[b]    <= 1'b0;
                    bridge_drive_o[b] <= 1'b0;
                end else begin
                    bridge_en_o[b]    <= enabled;
                    bridge_drive_o[b] <= enabled && (state_q == CH_DRIVE);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Fault line and charge pump
    logic any_fault;

    assign any_fault = sense_i.supply_low || sense_i.pump_low
                    || sense_i.thermal || (|oc_trip_q);

    assign fault_flag_low_o = 1'b0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_flag_low_oe_o <= 1'b0;
            pump_en_o           <= 1'b0;
        end else begin
            fault_flag_low_oe_o <= any_fault;
            pump_en_o           <= !sense_i.supply_low;
        end
    end

    // ==========================================================
    // Interrupt events: rising edge of each fault source
    logic [IRQ_W-1:0] src_q;
    logic [IRQ_W-1:0] src;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        src              = '0;
        src[IRQ_SUPPLY]  = sense_i.supply_low;
        src[IRQ_PUMP]    = sense_i.pump_low;
        src[IRQ_OVERCUR] = |oc_trip_q;
        src[IRQ_THERMAL] = sense_i.thermal;
    end

    assign irq_ev = src & ~src_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_q <= '0;
        end else begin
            src_q <= src;
        end
    end

    // ==========================================================
    // AHB-Lite slave: zero-wait writes, one wait state on reads
    logic        wr_q;
    logic        rd_q;
    logic [11:0] addr_q;
    logic        accept;
    logic [31:0] rd_mux;
    bct_status_t status;

    assign accept      = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = !rd_q;
    assign hresp_o     = 1'b0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_q <= accept && hwrite_i;
            rd_q <= accept && !hwrite_i;
            if (accept) begin
                addr_q <= (haddr_i[31:12] == 20'h00000) ? haddr_i[11:0] : 12'hFFF;
            end
        end
    end

    always_comb begin
        status            = '0;
        status.supply_low = sense_i.supply_low;
        status.pump_low   = sense_i.pump_low;
        status.thermal    = sense_i.thermal;
        status.oc_trip    = oc_trip_q;
        status.retry_mode = retry_mode;
        status.fault_line = fault_flag_low_i;
        status.off_time   = lvl_off_sel;
        status.step_a     = lvl_step_a;
        status.step_b     = lvl_step_b;
        status.decay_a    = lvl_decay_a;
        status.decay_b    = lvl_decay_b;
        status.enable     = lvl_enable;
        status.chop_off   = chop_off;
    end

    always_comb begin
        unique case (addr_q)
            OFS_STATUS:     rd_mux = status;
            OFS_IRQ_STATUS: rd_mux = {{(32-IRQ_W){1'b0}}, irq_sts_q};
            OFS_IRQ_ENABLE: rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_q};
            OFS_CTRL:       rd_mux = ctrl_q;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_q) begin
            hrdata_o <= rd_mux;
        end
    end

    assign irq_clr = (wr_q && addr_q == OFS_IRQ_CLEAR) ? hwdata_i[IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en_q <= IRQ_ENABLE_RST;
            ctrl_q   <= CTRL_RST;
        end else if (wr_q) begin
            if (addr_q == OFS_IRQ_ENABLE) begin
                irq_en_q <= hwdata_i[IRQ_W-1:0];
            end
            if (addr_q == OFS_CTRL) begin
                ctrl_q <= {31'h0000_0000, hwdata_i[CTRL_RUN]};
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_sts_q & ~irq_clr) | irq_ev) & irq_en_q);
        end
    end

endmodule

`default_nettype wire

// *** bct_supervisor_sva.sv ***
// Concurrent checks on the supervisor top-level ports
`timescale 1ns/1ns
`default_nettype none

module bct_supervisor_sva
    import bct_pkg::*;
(
    input wire logic                ref_clk_i,
    input wire logic                rst_n_i,
    input wire bct_pkg::bct_pins_t  pins_i,
    input wire bct_pkg::bct_sense_t sense_i,
    input wire logic                fault_flag_low_o,
    input wire logic                fault_flag_low_oe_o,
    input wire logic [1:0]          bridge_en_o,
    input wire logic [1:0]          bridge_drive_o,
    input wire logic                pump_en_o
);
    logic [7:0] on_cnt_q;
    logic [7:0] il_cnt_q;

    // ==========
    // Length of the running drive phase of bridge 0
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) on_cnt_q <= 8'h00;
        else on_cnt_q <= !bridge_drive_o[0] ? 8'h00 : on_cnt_q + {7'h00, on_cnt_q != 8'hFF};
    end

    // Consecutive cycles of current limit on bridge 0
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) il_cnt_q <= 8'h00;
        else il_cnt_q <= !sense_i.ilimit[0] ? 8'h00 : il_cnt_q + {7'h00, il_cnt_q != 8'hFF};
    end

    // ==========
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_supply_off: assert property (sense_i.supply_low |=>
        !pump_en_o && fault_flag_low_oe_o && bridge_en_o == 2'h0)
        else $error("supply low left bridges, pump or fault line wrong");
    a_pump_keep: assert property (sense_i.pump_low && !sense_i.supply_low |=>
        pump_en_o && fault_flag_low_oe_o && bridge_en_o == 2'h0)
        else $error("pump low handled wrongly");
    a_heat_off: assert property (sense_i.thermal && !sense_i.supply_low |=>
        pump_en_o && fault_flag_low_oe_o && bridge_en_o == 2'h0)
        else $error("overtemperature handled wrongly");
    a_fault_release: assert property ($fell(fault_flag_low_oe_o) |->
        $past(sense_i.supply_low || sense_i.pump_low || sense_i.thermal) == 1'b0)
        else $error("fault line released while a source was active");
    a_drain_only: assert property (fault_flag_low_o == 1'b0)
        else $error("fault pin driven high");
    a_hiz_disable: assert property (pins_i.enable == 2'h0 |=> bridge_en_o == 2'h0)
        else $error("bridges enabled while enable pin low");
    a_min_drive: assert property ($fell(bridge_drive_o[0]) && bridge_en_o[0] |->
        on_cnt_q >= 8'd18)
        else $error("drive phase shorter than blanking");
    a_oc_filter: assert property (il_cnt_q == 8'd40 |-> ##[0:2]
        (!bridge_en_o[0] && fault_flag_low_oe_o))
        else $error("overcurrent not tripped after filter time");
    a_pump_on: assert property (rst_n_i && !sense_i.supply_low |=> pump_en_o)
        else $error("charge pump off without supply low");
endmodule

`default_nettype wire

// *** bct_ctrl_model.sv ***
// External controller: fault line pull-up and sleep reset pulses
`timescale 1ns/1ns
`default_nettype none

module bct_ctrl_model (
    input  wire logic        ref_clk_i,
    input  wire logic        pull_low_i,
    input  wire logic        pulse_go_i,
    input  wire logic [11:0] pulse_len_i,
    output logic             fault_line_o,
    output logic             sleep_request_low_o
);
    logic [11:0] left_q = 12'h000;

    // ==========
    // Pull-up restores the line once the drain lets go
    assign fault_line_o = pull_low_i ? 1'b0 : 1'b1;

    // Sleep pin held low for the requested count of cycles
    always @(posedge ref_clk_i) begin
        if (pulse_go_i) left_q <= pulse_len_i;
        else if (left_q != 12'h000) left_q <= left_q - 12'h001;
    end
    assign sleep_request_low_o = (left_q == 12'h000);
endmodule

`default_nettype wire

// *** test_bct_supervisor.sv ***
// Self-checking testbench of the chop timing and fault supervisor
`timescale 1ns/1ns
`default_nettype none

module test_bct_supervisor;
    import bct_pkg::*;
    localparam int unsigned RETRY = 50;
    logic        ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic        rd_pend = 1'b0, pin_look = 1'b0, off_look = 1'b0;
    logic        hready, hresp, fault_o, fault_oe, pump, irq, fault_wire, sleep_low;
    logic [1:0]  htrans = 2'h0;
    logic [1:0]  en, drive;
    logic [11:0] plen = 12'h000;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [31:0] hrdata;
    bct_pins_t   pins = 12'h001;
    bct_sense_t  sense = 7'h00;
    logic [31:0] exp_q [$];
    int          err_total = 0, tests_run = 0, seed = 32'h16B49879, i, low_cnt = 0;
    int          offc [4] = '{OFF_US_LOW * CLK_MHZ, OFF_US_HIGH * CLK_MHZ,
                              OFF_US_OPEN * CLK_MHZ, OFF_US_RGND * CLK_MHZ};
    int          sbit [3] = '{6, 5, 4};
    logic [31:0] ibit [3] = '{32'h1, 32'h2, 32'h8};
    logic [4:0]  fexp [3] = '{5'h18, 5'h19, 5'h19};

    always #25 ref_clk = ~ref_clk;

    bct_supervisor #(.RETRY_CYC(RETRY)) i_dut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .pins_i(pins), .sense_i(sense), .sleep_request_low_i(sleep_low),
        .fault_flag_low_i(fault_wire), .fault_flag_low_o(fault_o),
        .fault_flag_low_oe_o(fault_oe), .bridge_en_o(en), .bridge_drive_o(drive),
        .pump_en_o(pump), .irq_o(irq)
    );

    bct_ctrl_model i_ctrl (
        .ref_clk_i(ref_clk), .pull_low_i(fault_oe), .pulse_go_i(go), .pulse_len_i(plen),
        .fault_line_o(fault_wire), .sleep_request_low_o(sleep_low)
    );

    // ==========
    // Watcher: takes the oldest note whenever a result shows
    task automatic check(input logic [31:0] act);
        logic [31:0] e;
        e = exp_q.pop_front();
        tests_run++;
        if (act !== e) begin
            err_total++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, act);
        end
    endtask

    always @(negedge ref_clk) begin
        if (drive[0]) begin
            if (off_look && low_cnt > 0) check(low_cnt);
            low_cnt = 0;
        end else low_cnt = low_cnt + 1;
        if (rd_pend && hready) check(hrdata);
        if (pin_look) check({26'h0, hresp, irq, fault_oe, en, pump});
    end

    // ==========
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic limit(input int k, input int lim);
        if (k >= lim) begin
            err_total++;
            finish_test();
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask

    task automatic rdy();
        int k;
        for (k = 0; k < 20; k++) begin
            @(negedge ref_clk);
            if (hready) break;
        end
        limit(k, 20);
        @(posedge ref_clk);
    endtask

    // Single word transfer; on a read d is the expected data
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h00000, a};
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr) exp_q.push_back(d);
        rd_pend <= !wr;
        rdy();
        rd_pend <= 1'b0;
    endtask

    task automatic pin(input logic [4:0] e);
        exp_q.push_back({27'h0, e});
        pin_look <= 1'b1;
        @(posedge ref_clk);
        pin_look <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic pulse(input int len);
        plen <= len[11:0];
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        cyc(len + 10);
    endtask

    // Measures one whole off phase after a select change
    task automatic off_run(input logic [1:0] lvl, input int cyc_n);
        int k;
        pins.off_time_select <= lvl;
        for (k = 0; k < 1500; k++) begin
            @(negedge ref_clk);
            if (drive[0]) break;
        end
        @(posedge ref_clk);
        exp_q.push_back(cyc_n);
        off_look <= 1'b1;
        for (k = 0; k < 1500 && exp_q.size() != 0; k++) @(posedge ref_clk);
        off_look <= 1'b0;
        @(posedge ref_clk);
        limit(k, 1500);
    endtask

    function automatic logic [1:0] t3(input logic [1:0] v);
        return (v == 2'h3) ? 2'h2 : v;
    endfunction

    // ==========
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        pin(5'h07);
        bus(1'b0, OFS_IRQ_ENABLE, 32'h0);
        bus(1'b0, OFS_CTRL, CTRL_RST);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            pins.step_size_sel_a <= r[1:0];
            pins.step_size_sel_b <= r[3:2];
            pins.decay_sel_a <= r[5:4];
            pins.decay_sel_b <= r[7:6];
            cyc(2);
            bus(1'b0, OFS_STATUS, {13'h0, 2'h1, t3(r[7:6]), t3(r[5:4]), r[3:2], t3(r[1:0]), 9'h060});
        end
        bus(1'b1, OFS_IRQ_ENABLE, 32'hF);
        for (i = 0; i < 3; i++) begin
            sense[sbit[i]] <= 1'b1;
            cyc(2);
            pin(fexp[i]);
            bus(1'b0, OFS_IRQ_STATUS, ibit[i]);
            sense[sbit[i]] <= 1'b0;
            cyc(2);
            pin(5'h17);
            bus(1'b1, OFS_IRQ_CLEAR, ibit[i]);
            cyc(2);
            pin(5'h07);
        end
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
        sense.thermal <= 1'b1;
        cyc(2);
        pin(5'h09);
        sense.thermal <= 1'b0;
        bus(1'b0, OFS_IRQ_STATUS, 32'h8);
        bus(1'b1, OFS_IRQ_CLEAR, 32'h8);
        bus(1'b1, 12'h040, 32'hFFFF_FFFF);
        bus(1'b0, 12'h040, 32'h0);
        bus(1'b0, OFS_IRQ_CLEAR, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h0);
        cyc(2);
        pin(5'h01);
        bus(1'b1, OFS_CTRL, 32'h1);
        pins.enable <= 2'h0;
        cyc(2);
        pin(5'h01);
        pins.enable <= 2'h1;
        sense.ilimit <= 2'h1;
        cyc(39);
        sense.ilimit <= 2'h0;
        cyc(3);
        pin(5'h07);
        sense.ilimit <= 2'h1;
        cyc(40);
        sense.ilimit <= 2'h0;
        cyc(2);
        pin(5'h0D);
        cyc(RETRY - 20);
        pin(5'h0D);
        cyc(20);
        pin(5'h07);
        sense.ilimit <= 2'h2;
        cyc(RETRY + 60);
        pin(5'h0B);
        sense.ilimit <= 2'h0;
        cyc(RETRY + 3);
        pin(5'h07);
        pins.enable <= 2'h2;
        sense.ilimit <= 2'h1;
        cyc(40);
        sense.ilimit <= 2'h0;
        cyc(RETRY + 20);
        pin(5'h0D);
        pulse(300);
        pin(5'h0D);
        pulse(500);
        pin(5'h07);
        pins.enable <= 2'h1;
        sense.sense_trip <= 2'h3;
        for (i = 0; i < 4; i++) off_run(i[1:0], offc[i]);
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
endmodule

bind bct_supervisor bct_supervisor_sva i_sva (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pins_i(pins_i), .sense_i(sense_i),
    .fault_flag_low_o(fault_flag_low_o), .fault_flag_low_oe_o(fault_flag_low_oe_o),
    .bridge_en_o(bridge_en_o), .bridge_drive_o(bridge_drive_o), .pump_en_o(pump_en_o)
);

`default_nettype wire
